/* File: rtl/wwc_pkg.sv */
// Constants, field layouts and carrier types of the watchdog window configuration block.
// Assumes a single 10 MHz clock and an AXI4-Lite register bus with 32-bit data.
package wwc_pkg;

  // ==========================================================================
  // Clock and bus
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h14;

  // ==========================================================================
  // Field positions and codes
  // ==========================================================================
  localparam int CTRL_WIN_LSB = 0;
  localparam int CTRL_CS_LSB = 4;
  localparam int CFG_CS_LSB = 0;
  localparam int CFG_IV_LSB = 8;
  localparam int ST_OPEN = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_BADCLR = 2;
  localparam int ST_SRC_OK = 3;
  localparam int CLEAR_BIT = 0;
  localparam logic [2:0] CODE_ALL_ONES = 3'h7;
  localparam logic [2:0] CS_LOW_FREQ = 3'h0;
  localparam logic [2:0] CS_MID_FREQ = 3'h1;
  localparam logic [2:0] CS_RESET_FORCED = 3'h0;
  localparam logic [15:0] PERIOD_RESET = 16'h0400;
  localparam int EIGHTHS_SHIFT = 3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [2:0] clock_select;
    logic [2:0] window_select;
  } wwc_ctrl_s;

  typedef struct packed {
    logic [2:0] cfg_clock_select_default;
    logic [2:0] cfg_interval_default;
  } wwc_cfg_s;

  typedef enum logic [1:0] {
    PH_CLOSED = 2'b01,
    PH_OPEN = 2'b10
  } wwc_phase_e;

  // Closed part of the period in eighths: code 7 gives none, codes 6..0 give 1..7.
  function automatic logic [2:0] wwc_delay_eighths(input logic [2:0] code);
    logic [2:0] res;
    res = (code == CODE_ALL_ONES) ? 3'h0 : 3'(CODE_ALL_ONES - code);
    return res;
  endfunction

  // A field is writable by software only when its configuration default is all ones.
  function automatic logic wwc_cfg_unlocked(input logic [2:0] cfg_field);
    return cfg_field == CODE_ALL_ONES;
  endfunction

endpackage

/* File: rtl/wwc_clock_select.sv */
// Watchdog clock source selector producing a registered tick.
// Assumes oscillator ticks arrive as one-cycle pulses synchronous to the clock.
`timescale 1ns/1ps
module wwc_clock_select (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sel_i,
  input wire logic low_freq_internal_osc_i,
  input wire logic mid_freq_internal_osc_i,
  output logic tick_o,
  output logic src_ok_o
);

  // ==========================================================================
  // Source multiplexer
  // ==========================================================================
  logic tick_reg;
  logic tick_next;
  logic ok_reg;
  logic ok_next;

  always_comb
  begin
    tick_next = 1'b0;
    ok_next = 1'b1;
    if (sel_i == wwc_pkg::CS_LOW_FREQ)
    begin
      tick_next = low_freq_internal_osc_i;
    end
    else if (sel_i == wwc_pkg::CS_MID_FREQ)
    begin
      tick_next = mid_freq_internal_osc_i;
    end
    else
    begin
      ok_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tick_reg <= 1'b0;
      ok_reg <= 1'b1;
    end
    else
    begin
      tick_reg <= tick_next;
      ok_reg <= ok_next;
    end
  end

  assign tick_o = tick_reg;
  assign src_ok_o = ok_reg;

endmodule // wwc_clock_select

/* File: rtl/wwc_window_timer.sv */
// Watchdog period counter with a closed and an open clear window.
// Assumes tick_i is a one-cycle pulse and clear_i a one-cycle request.
`timescale 1ns/1ps
module wwc_window_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [15:0] period_i,
  input wire logic [2:0] window_i,
  output logic [15:0] count_o,
  output logic open_o,
  output logic timeout_o,
  output logic bad_clear_o
);

  // ==========================================================================
  // Counter and phase
  // ==========================================================================
  logic [15:0] count_reg;
  logic [15:0] count_next;
  wwc_pkg::wwc_phase_e phase_reg;
  wwc_pkg::wwc_phase_e phase_next;
  logic timeout_reg;
  logic timeout_next;
  logic bad_reg;
  logic bad_next;
  logic [18:0] prod;
  logic [15:0] thr;
  logic [15:0] last;

  always_comb
  begin
    prod = 19'(period_i) * 19'(wwc_pkg::wwc_delay_eighths(window_i));
    thr = prod[18:wwc_pkg::EIGHTHS_SHIFT];
    last = (period_i == 16'h0000) ? 16'h0000 : 16'(period_i - 16'h0001);
    count_next = count_reg;
    timeout_next = 1'b0;
    bad_next = 1'b0;
    if (clear_i && phase_reg == wwc_pkg::PH_CLOSED)
    begin
      bad_next = 1'b1;
    end
    if (clear_i && phase_reg == wwc_pkg::PH_OPEN)
    begin
      count_next = 16'h0000;
    end
    else if (tick_i)
    begin
      if (count_reg >= last)
      begin
        count_next = 16'h0000;
        timeout_next = 1'b1;
      end
      else
      begin
        count_next = 16'(count_reg + 16'h0001);
      end
    end
    phase_next = (count_next >= thr) ? wwc_pkg::PH_OPEN : wwc_pkg::PH_CLOSED;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      count_reg <= 16'h0000;
      phase_reg <= wwc_pkg::PH_CLOSED;
      timeout_reg <= 1'b0;
      bad_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      phase_reg <= phase_next;
      timeout_reg <= timeout_next;
      bad_reg <= bad_next;
    end
  end

  assign count_o = count_reg;
  assign open_o = (phase_reg == wwc_pkg::PH_OPEN);
  assign timeout_o = timeout_reg;
  assign bad_clear_o = bad_reg;

endmodule // wwc_window_timer

/* File: rtl/wwc_top.sv */
// Watchdog window and clock-source configuration with an AXI4-Lite register slave.
// Assumes configuration defaults are static levels and oscillator ticks are clock-synchronous pulses.
//
// Functional notes
// - Window code 111 gives no closed delay and keeps the clear window open for the whole period.
// - Window codes 110 down to 000 close 12.5 to 87.5 percent of the period in eighths, the rest open.
// - A clock-select default of 111 resets the runtime clock select to 000.
// - Reset loads the runtime window select from the configured window default.
// - Unless the clock-select default is 111, the runtime clock select ignores software writes.
// - Unless the window default is 111, the runtime window select ignores software writes.
// - Clock select 000 takes the low-frequency oscillator, 001 the mid-frequency one, others reserved.
// - Control word holds window in bits 2..0, clock select in bits 6..4, bits 7 and 3 read zero.
`timescale 1ns/1ps
module wwc_top (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [2:0] CFG_CLOCK_SELECT_DEFAULT_I,
  input wire logic [2:0] CFG_INTERVAL_DEFAULT_I,
  input wire logic LOW_FREQ_INTERNAL_OSC_I,
  input wire logic MID_FREQ_INTERNAL_OSC_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic WINDOW_OPEN_O,
  output logic TIMEOUT_O
);

  // ==========================================================================
  // Write channel capture
  // ==========================================================================
  logic aw_hold_reg;
  logic aw_hold_next;
  logic [7:0] aw_addr_reg;
  logic [7:0] aw_addr_next;
  logic w_hold_reg;
  logic w_hold_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0] w_strb_reg;
  logic [3:0] w_strb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic do_write;
  logic wr_known;

  assign S_AXI_AWREADY_O = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY_O = !w_hold_reg && !bvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    wr_known = (aw_addr_reg == wwc_pkg::OFF_CTRL) || (aw_addr_reg == wwc_pkg::OFF_PERIOD) ||
               (aw_addr_reg == wwc_pkg::OFF_CLEAR) || (aw_addr_reg == wwc_pkg::OFF_STATUS);
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O)
    begin
      w_hold_next = 1'b1;
      w_data_next = S_AXI_WDATA_I;
      w_strb_next = S_AXI_WSTRB_I;
    end
    if (do_write)
    begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_known ? wwc_pkg::RESP_OKAY : wwc_pkg::RESP_SLVERR;
    end
    else if (bvalid_reg && S_AXI_BREADY_I)
    begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= wwc_pkg::RESP_OKAY;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;

  // ==========================================================================
  // Configuration word and control register
  // ==========================================================================
  wwc_pkg::wwc_cfg_s cfg_reg;
  wwc_pkg::wwc_cfg_s cfg_next;
  wwc_pkg::wwc_ctrl_s ctrl_reg;
  wwc_pkg::wwc_ctrl_s ctrl_next;
  wwc_pkg::wwc_ctrl_s ctrl_rst;
  logic [15:0] period_reg;
  logic [15:0] period_next;
  logic wr_ctrl;
  logic wr_period;
  logic wr_status;
  logic clear_req;

  assign wr_ctrl = do_write && (aw_addr_reg == wwc_pkg::OFF_CTRL) && w_strb_reg[0];
  assign wr_period = do_write && (aw_addr_reg == wwc_pkg::OFF_PERIOD);
  assign wr_status = do_write && (aw_addr_reg == wwc_pkg::OFF_STATUS) && w_strb_reg[0];
  assign clear_req = do_write && (aw_addr_reg == wwc_pkg::OFF_CLEAR) && w_strb_reg[0] &&
                     w_data_reg[wwc_pkg::CLEAR_BIT];

  always_comb
  begin
    cfg_next.cfg_clock_select_default = CFG_CLOCK_SELECT_DEFAULT_I;
    cfg_next.cfg_interval_default = CFG_INTERVAL_DEFAULT_I;
    ctrl_rst.clock_select = CFG_CLOCK_SELECT_DEFAULT_I;
    if (wwc_pkg::wwc_cfg_unlocked(CFG_CLOCK_SELECT_DEFAULT_I))
      ctrl_rst.clock_select = wwc_pkg::CS_RESET_FORCED;
    ctrl_rst.window_select = CFG_INTERVAL_DEFAULT_I;
    ctrl_next = ctrl_reg;
    if (wr_ctrl && wwc_pkg::wwc_cfg_unlocked(cfg_reg.cfg_clock_select_default))
      ctrl_next.clock_select = w_data_reg[wwc_pkg::CTRL_CS_LSB +: 3];
    if (wr_ctrl && wwc_pkg::wwc_cfg_unlocked(cfg_reg.cfg_interval_default))
      ctrl_next.window_select = w_data_reg[wwc_pkg::CTRL_WIN_LSB +: 3];
    period_next = period_reg;
    if (wr_period && w_strb_reg[0])
      period_next[7:0] = w_data_reg[7:0];
    if (wr_period && w_strb_reg[1])
      period_next[15:8] = w_data_reg[15:8];
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      cfg_reg <= cfg_next;
      ctrl_reg <= ctrl_rst;
      period_reg <= wwc_pkg::PERIOD_RESET;
    end
    else
    begin
      cfg_reg <= cfg_reg;
      ctrl_reg <= ctrl_next;
      period_reg <= period_next;
    end
  end

  // ==========================================================================
  // Clock source and window timer
  // ==========================================================================
  logic wdt_tick;
  logic src_ok;
  logic [15:0] count;
  logic win_open;
  logic timeout_pulse;
  logic bad_clear_pulse;

  wwc_clock_select u_clock_select (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .sel_i(ctrl_reg.clock_select),
    .low_freq_internal_osc_i(LOW_FREQ_INTERNAL_OSC_I),
    .mid_freq_internal_osc_i(MID_FREQ_INTERNAL_OSC_I),
    .tick_o(wdt_tick),
    .src_ok_o(src_ok)
  );

  wwc_window_timer u_window_timer (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .tick_i(wdt_tick),
    .clear_i(clear_req),
    .period_i(period_reg),
    .window_i(ctrl_reg.window_select),
    .count_o(count),
    .open_o(win_open),
    .timeout_o(timeout_pulse),
    .bad_clear_o(bad_clear_pulse)
  );

  // ==========================================================================
  // Sticky status flags
  // ==========================================================================
  logic timeout_flag_reg;
  logic timeout_flag_next;
  logic bad_flag_reg;
  logic bad_flag_next;

  always_comb
  begin
    timeout_flag_next = timeout_flag_reg;
    bad_flag_next = bad_flag_reg;
    if (wr_status && w_data_reg[wwc_pkg::ST_TIMEOUT])
      timeout_flag_next = 1'b0;
    if (wr_status && w_data_reg[wwc_pkg::ST_BADCLR])
      bad_flag_next = 1'b0;
    if (timeout_pulse)
      timeout_flag_next = 1'b1;
    if (bad_clear_pulse)
      bad_flag_next = 1'b1;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      timeout_flag_reg <= 1'b0;
      bad_flag_reg <= 1'b0;
    end
    else
    begin
      timeout_flag_reg <= timeout_flag_next;
      bad_flag_reg <= bad_flag_next;
    end
  end

  assign WINDOW_OPEN_O = win_open;
  assign TIMEOUT_O = timeout_pulse;

  // ==========================================================================
  // Read channel
  // ==========================================================================
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [31:0] rd_word;
  logic rd_known;

  assign S_AXI_ARREADY_O = !rvalid_reg;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_known = 1'b1;
    unique case (S_AXI_ARADDR_I)
      wwc_pkg::OFF_CTRL:
      begin
        rd_word[wwc_pkg::CTRL_WIN_LSB +: 3] = ctrl_reg.window_select;
        rd_word[wwc_pkg::CTRL_CS_LSB +: 3] = ctrl_reg.clock_select;
      end
      wwc_pkg::OFF_CONFIG:
      begin
        rd_word[wwc_pkg::CFG_CS_LSB +: 3] = cfg_reg.cfg_clock_select_default;
        rd_word[wwc_pkg::CFG_IV_LSB +: 3] = cfg_reg.cfg_interval_default;
      end
      wwc_pkg::OFF_PERIOD: rd_word[15:0] = period_reg;
      wwc_pkg::OFF_CLEAR: rd_word = 32'h0000_0000;
      wwc_pkg::OFF_STATUS:
      begin
        rd_word[wwc_pkg::ST_OPEN] = win_open;
        rd_word[wwc_pkg::ST_TIMEOUT] = timeout_flag_reg;
        rd_word[wwc_pkg::ST_BADCLR] = bad_flag_reg;
        rd_word[wwc_pkg::ST_SRC_OK] = src_ok;
      end
      wwc_pkg::OFF_COUNT: rd_word[15:0] = count;
      default: rd_known = 1'b0;
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_known ? wwc_pkg::RESP_OKAY : wwc_pkg::RESP_SLVERR;
    end
    else if (rvalid_reg && S_AXI_RREADY_I)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= wwc_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;

endmodule // wwc_top

/* File: test/wwc_top_asserts.sv */
// Concurrent checks on the ports of the watchdog window configuration block.
// Assumes it is bound to wwc_top and sees nothing but its ports.
`timescale 1ns/1ps
module wwc_top_asserts (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [2:0] CFG_CLOCK_SELECT_DEFAULT_I,
  input wire logic [2:0] CFG_INTERVAL_DEFAULT_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic [7:0] rd_addr_reg, rd_addr_next;
  logic [2:0] cs_cfg_reg, cs_cfg_next, iv_cfg_reg, iv_cfg_next;
  logic ctrl_wr_reg, ctrl_wr_next;
  wire rd_ctrl = rd_addr_reg == wwc_pkg::OFF_CTRL;
  always_comb
  begin
    rd_addr_next = (S_AXI_ARVALID_I && S_AXI_ARREADY_O) ? S_AXI_ARADDR_I : rd_addr_reg;
    cs_cfg_next = RST_N_I ? cs_cfg_reg : CFG_CLOCK_SELECT_DEFAULT_I;
    iv_cfg_next = RST_N_I ? iv_cfg_reg : CFG_INTERVAL_DEFAULT_I;
    ctrl_wr_next = RST_N_I && (ctrl_wr_reg || (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
      S_AXI_AWADDR_I == wwc_pkg::OFF_CTRL));
  end
  always_ff @(posedge CLK_I)
  begin
    rd_addr_reg <= rd_addr_next;
    cs_cfg_reg <= cs_cfg_next;
    iv_cfg_reg <= iv_cfg_next;
    ctrl_wr_reg <= ctrl_wr_next;
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking dcb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  property p_rd_lat;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not one cycle after address");
  property p_rd_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped before ready");
  property p_wr_lat;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response not two cycles after handshake");
  property p_b_block;
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write accepted while response pending");
  property p_ctrl_bits;
    S_AXI_RVALID_O && rd_ctrl |-> S_AXI_RDATA_O[31:7] == 25'h0 && !S_AXI_RDATA_O[3];
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control word spare bits not zero");
  property p_cs_lock;
    S_AXI_RVALID_O && rd_ctrl && cs_cfg_reg != 3'h7 |-> S_AXI_RDATA_O[6:4] == cs_cfg_reg;
  endproperty
  a_cs_lock: assert property (p_cs_lock) else $error("locked clock select changed");
  property p_win_lock;
    S_AXI_RVALID_O && rd_ctrl && iv_cfg_reg != 3'h7 |-> S_AXI_RDATA_O[2:0] == iv_cfg_reg;
  endproperty
  a_win_lock: assert property (p_win_lock) else $error("locked window select changed");
  property p_cs_reset;
    S_AXI_RVALID_O && rd_ctrl && cs_cfg_reg == 3'h7 && !ctrl_wr_reg |-> S_AXI_RDATA_O[6:4] == 3'h0;
  endproperty
  a_cs_reset: assert property (p_cs_reset) else $error("clock select reset value wrong");
  property p_unmapped;
    S_AXI_RVALID_O && rd_addr_reg > 8'h17 |-> S_AXI_RRESP_O == wwc_pkg::RESP_SLVERR && S_AXI_RDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule // wwc_top_asserts

bind wwc_top wwc_top_asserts i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CFG_CLOCK_SELECT_DEFAULT_I(CFG_CLOCK_SELECT_DEFAULT_I), .CFG_INTERVAL_DEFAULT_I(CFG_INTERVAL_DEFAULT_I),
  .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I));

/* File: test/wwc_top_bench.sv */
// Self-checking bench of the watchdog window configuration block.
// Assumes the register map and bus timing of wwc_pkg and a 10 MHz clock.
`timescale 1ns/1ps
module wwc_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cfg_cs = 3'h7;
  logic [2:0] cfg_iv = 3'h7;
  logic low_osc = 1'b0;
  logic mid_osc = 1'b0;
  logic [1:0] osc_ph = 2'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, win_open, timeout;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [65:0] exp_r;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int tq_cyc[$];
  int tq_open[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int arm = 0;
  int n_cyc = 0;
  int n_open = 0;

  wwc_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CFG_CLOCK_SELECT_DEFAULT_I(cfg_cs),
    .CFG_INTERVAL_DEFAULT_I(cfg_iv), .LOW_FREQ_INTERNAL_OSC_I(low_osc), .MID_FREQ_INTERNAL_OSC_I(mid_osc),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .WINDOW_OPEN_O(win_open), .TIMEOUT_O(timeout));

  // ==========================================================================
  // Clock, oscillator ticks and result monitor
  // ==========================================================================
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    osc_ph <= osc_ph + 2'h1;
    low_osc <= !low_osc;
    mid_osc <= osc_ph == 2'h3;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk)
  begin
    n_cyc++;
    if (win_open === 1'b1)
      n_open++;
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
    begin
      exp_r = rq.pop_front();
      check(rdata & exp_r[63:32], exp_r[31:0]);
      check({30'h0, rresp}, {30'h0, exp_r[65:64]});
    end
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
      check({30'h0, bresp}, {30'h0, bq.pop_front()});
    if (timeout === 1'b1)
    begin
      if (arm == 2)
      begin
        check(n_cyc, tq_cyc.pop_front());
        check(n_open, tq_open.pop_front());
        arm = 0;
      end
      if (arm == 1)
        arm = 2;
      n_cyc = 0;
      n_open = 0;
    end
  end

  // ==========================================================================
  // Bus and test tasks
  // ==========================================================================
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= {2'($urandom), 2'b11};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100)
      n_mismatch++;
    @(posedge clk);
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    int n;
    rq.push_back({r, m, e});
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom);
    do
    begin
      @(posedge clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready !== 1'b1)
        rready <= 1'b1;
      n++;
    end
    while ((rvalid !== 1'b1 || rready !== 1'b1) && n < 100);
    rready <= 1'b0;
    if (n >= 100)
      n_mismatch++;
    @(posedge clk);
  endtask
  task automatic lock_case(input logic [2:0] cs, input logic [2:0] iv, input logic [31:0] d);
    logic [2:0] ecs;
    logic [2:0] eiv;
    rst_n <= 1'b0;
    cfg_cs <= cs;
    cfg_iv <= iv;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ecs = (cs == 3'h7) ? 3'h0 : cs;
    eiv = iv;
    axi_read(wwc_pkg::OFF_CTRL, {25'h0, ecs, 1'b0, eiv}, 32'hFFFF_FFFF, wwc_pkg::RESP_OKAY);
    axi_read(wwc_pkg::OFF_CONFIG, {21'h0, iv, 5'h0, cs}, 32'hFFFF_FFFF, wwc_pkg::RESP_OKAY);
    axi_write(wwc_pkg::OFF_CTRL, d, wwc_pkg::RESP_OKAY);
    if (cs == 3'h7)
      ecs = d[6:4];
    if (iv == 3'h7)
      eiv = d[2:0];
    axi_read(wwc_pkg::OFF_CTRL, {25'h0, ecs, 1'b0, eiv}, 32'hFFFF_FFFF, wwc_pkg::RESP_OKAY);
    $display("lock test %h %h done", cs, iv);
  endtask
  task automatic timer_case(input logic [2:0] cs, input logic [2:0] code, input int p);
    int sp;
    int k;
    sp = (cs == 3'h0) ? 2 : 4;
    tq_cyc.push_back(sp * p);
    tq_open.push_back(sp * (p - ((p * (7 - int'(code))) >> 3)));
    axi_write(wwc_pkg::OFF_PERIOD, 32'(p), wwc_pkg::RESP_OKAY);
    axi_write(wwc_pkg::OFF_CTRL, {25'h0, cs, 1'b0, code}, wwc_pkg::RESP_OKAY);
    arm = 1;
    k = 0;
    while (arm != 0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (arm != 0)
      n_mismatch++;
    @(posedge clk);
    $display("timer test %h %h done", cs, code);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial
  begin
    void'($urandom(32'ha2d6));
    @(posedge clk);
    lock_case(3'h7, 3'h7, $urandom | 32'h0000_0088);
    lock_case(3'(1 + $urandom % 6), 3'h7, $urandom);
    lock_case(3'h7, 3'($urandom % 7), $urandom);
    lock_case(3'($urandom % 7), 3'($urandom % 7), $urandom);
    lock_case(3'h7, 3'h7, 32'h0000_0077);
    axi_read(wwc_pkg::OFF_STATUS, 32'h0, 32'h0000_0008, wwc_pkg::RESP_OKAY);
    axi_read(8'h18, 32'h0, 32'hFFFF_FFFF, wwc_pkg::RESP_SLVERR);
    axi_write(wwc_pkg::OFF_CONFIG, $urandom, wwc_pkg::RESP_SLVERR);
    axi_write(wwc_pkg::OFF_CTRL, 32'h0000_0007, wwc_pkg::RESP_OKAY);
    axi_write(wwc_pkg::OFF_CLEAR, 32'h0000_0001, wwc_pkg::RESP_OKAY);
    for (int c = 0; c < 8; c++)
      timer_case(3'h0, 3'(c), 8 + int'($urandom % 8));
    timer_case(3'h1, 3'h7, 8 + int'($urandom % 8));
    timer_case(3'h1, 3'h2, 8 + int'($urandom % 8));
    final_report();
  end
  initial
  begin
    #(100 * 40000);
    n_mismatch++;
    final_report();
  end
endmodule // wwc_top_bench
